/* rtl/sadc_pkg.sv */
// Purpose: shared constants for the converter control block
// Assumes: 40 MHz pclk, 32-bit APB, byte address = 4 * register index
// Notes: register indices are kept; the bus decodes index * 4
//
// Functional notes
// R1: converter-on starts continuous conversions of input
// R2: clearing converter-on (bit 5) stops conversion
// R3: each conversion sets flag bit 7, stores result
// R4: high read or control write clears flag
// R5: input change aborts, clears flag, restarts
// R6: input select is binary index 0..15
// R7: bit 6 picks pclk/4 (0) or pclk/2
// R8: high register shows result bits 9:2
// R9: low register shows bits 1:0, rest zero
// R10: above upper reference reads full scale
// R11: below lower reference reads all zero
// R12: software reads both before next completion
// R13: 10-bit read: poll, low, then high
// R14: 8-bit read: poll, then high only
// R15: software writes reserved bit 4 as zero
// R16: wait mode leaves conversions unchanged
// R17: halt disables; settle time after wakeup
// R18: all registers reset to zero
// R19: no interrupt; completion flag polled only
// R20: fixed converter clock periods per conversion
package sadc_pkg;
	// register indices and byte addresses
	localparam logic [7:0] CSR_IDX = 8'h70;
	localparam logic [7:0] DRH_IDX = 8'h71;
	localparam logic [7:0] DRL_IDX = 8'h72;
	localparam logic [9:0] CSR_ADDR = {CSR_IDX, 2'h0};
	localparam logic [9:0] DRH_ADDR = {DRH_IDX, 2'h0};
	localparam logic [9:0] DRL_ADDR = {DRL_IDX, 2'h0};
	// control/status fields
	localparam int EOC_BIT = 7;
	localparam int SPEED_BIT = 6;
	localparam int ON_BIT = 5;
	localparam int CH_LSB = 0;
	localparam int CH_W = 4;
	localparam logic [7:0] CSR_RESET = 8'h00;
	// result layout
	localparam int RES_W = 10;
	localparam int HI_LSB = 2;
	localparam int LO_W = 2;
	localparam logic [RES_W-1:0] RES_RESET = 10'h000;
	// divider terminal counts: ticks every count+1 pclk cycles
	localparam logic [1:0] DIV_SLOW = 2'h3;
	localparam logic [1:0] DIV_FAST = 2'h1;
	// converter ticks spent sampling before the bit trials
	localparam int SAMPLE_TICKS = 2;
	localparam int CNT_W = 4;
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETTLE_NS = 10000;
	localparam int SETTLE_CYC =
		(SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 16;
	// register select codes
	typedef enum logic [1:0] {
		SEL_CSR = 2'h0,
		SEL_DRH = 2'h1,
		SEL_DRL = 2'h2,
		SEL_NONE = 2'h3
	} sadc_sel_e;
endpackage : sadc_pkg

/* rtl/sadc_sar.sv */
// Purpose: successive approximation sequencer for one conversion loop
// Assumes: cmp_hi is already synchronised; tick is one pclk wide
// Notes: restarts by itself after every result while enabled
module sadc_sar #(
	parameter int RES_W = sadc_pkg::RES_W,
	parameter int SAMPLE_TICKS = sadc_pkg::SAMPLE_TICKS,
	parameter int CNT_W = sadc_pkg::CNT_W
) (
	// clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control
	input wire logic enable,
	input wire logic restart,
	input wire logic tick,
	input wire logic cmp_hi,
	// results and analog drive
	output logic done,
	output logic [RES_W-1:0] code,
	output logic sample
);
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SAMP = 2'b01,
		S_TRY = 2'b11,
		S_KEEP = 2'b10
	} sadc_sar_e;
	typedef struct packed {
		sadc_sar_e state;
		logic [CNT_W-1:0] cnt;
		logic [RES_W-1:0] code;
		logic done;
		logic sample;
	} sadc_sar_s;
	sadc_sar_s q_ff;
	sadc_sar_s nxt_q;

	always_comb begin
		nxt_q = q_ff;
		nxt_q.done = 1'b0;
		if (!enable) begin // see R2
			nxt_q.state = S_IDLE;
			nxt_q.code = '0;
			nxt_q.sample = 1'b0;
		end else if (restart || q_ff.state == S_IDLE) begin // see R5
			nxt_q.state = S_SAMP;
			nxt_q.cnt = '0;
			nxt_q.sample = 1'b1;
		end else if (tick) begin
			unique case (q_ff.state)
				S_SAMP: begin
					// fixed tick budget per conversion, see R20
					if (q_ff.cnt == CNT_W'(SAMPLE_TICKS - 1)) begin
						nxt_q.state = S_TRY;
						nxt_q.sample = 1'b0;
						nxt_q.cnt = CNT_W'(RES_W - 1);
						nxt_q.code = '0;
						nxt_q.code[RES_W-1] = 1'b1;
					end else begin
						nxt_q.cnt = q_ff.cnt + 1'b1;
					end
				end
				// one tick lets the comparator settle on the trial
				S_TRY: nxt_q.state = S_KEEP;
				S_KEEP: begin
					// saturates to all ones or zeros, see R10 see R11
					nxt_q.code[q_ff.cnt] = cmp_hi;
					if (q_ff.cnt == '0) begin
						nxt_q.done = 1'b1;
						nxt_q.state = S_SAMP; // see R1
						nxt_q.sample = 1'b1;
					end else begin
						nxt_q.cnt = q_ff.cnt - 1'b1;
						nxt_q.code[q_ff.cnt - 1'b1] = 1'b1;
						nxt_q.state = S_TRY;
					end
				end
				S_IDLE: nxt_q.state = S_SAMP;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff <= '0;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end

	assign done = q_ff.done;
	assign code = q_ff.code;
	assign sample = q_ff.sample;

	restart_samples_a: assert property ( // see R5
		@(posedge pclk) disable iff (!presetn)
		ce && enable && restart |=> sample && q_ff.state == S_SAMP
	) else $error("restart did not return to sampling");
endmodule : sadc_sar

/* rtl/sadc_ctrl.sv */
// Purpose: APB control, status and result registers of the converter
// Assumes: cmp_hi_async is asynchronous; halt_mode is on pclk
// Notes: one-cycle access phase; unmapped addresses answer pslverr
//
// The implementer's own choice: the APB interface to the registers.
module sadc_ctrl #(
	parameter int ADDR_W = 12,
	parameter int SETTLE_CYC = sadc_pkg::SETTLE_CYC
) (
	// clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// power management
	input wire logic halt_mode,
	input wire logic wait_mode,
	// analog front end
	input wire logic cmp_hi_async,
	output logic analog_power,
	output logic [sadc_pkg::CH_W-1:0] input_select,
	output logic [sadc_pkg::RES_W-1:0] dac_code,
	output logic sample_hold
);
	typedef struct packed {
		logic cmp_meta;
		logic cmp_sync;
		logic eoc;
		logic speed;
		logic on;
		logic [sadc_pkg::CH_W-1:0] ch;
		logic [sadc_pkg::RES_W-1:0] res;
		logic [1:0] div;
		logic [sadc_pkg::SETTLE_W-1:0] settle;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic power;
	} sadc_ctrl_s;

	localparam logic [sadc_pkg::SETTLE_W-1:0] SETTLE_LOAD =
		sadc_pkg::SETTLE_W'(SETTLE_CYC);

	sadc_ctrl_s q_ff;
	sadc_ctrl_s nxt_q;

	// address decode shared by the setup and access phases
	function automatic sadc_pkg::sadc_sel_e reg_sel(
		input logic [ADDR_W-1:0] addr
	);
		logic [9:0] low;
		low = addr[9:0];
		if (addr[ADDR_W-1:10] != '0) begin
			reg_sel = sadc_pkg::SEL_NONE;
		end else if (low == sadc_pkg::CSR_ADDR) begin
			reg_sel = sadc_pkg::SEL_CSR;
		end else if (low == sadc_pkg::DRH_ADDR) begin
			reg_sel = sadc_pkg::SEL_DRH;
		end else if (low == sadc_pkg::DRL_ADDR) begin
			reg_sel = sadc_pkg::SEL_DRL;
		end else begin
			reg_sel = sadc_pkg::SEL_NONE;
		end
	endfunction : reg_sel

	sadc_pkg::sadc_sel_e sel;
	logic setup;
	logic access;
	logic csr_wr;
	logic drh_rd;
	logic restart;
	logic sar_en;
	logic tick;
	logic sar_done;
	logic [sadc_pkg::RES_W-1:0] sar_code;
	logic sar_sample;
	logic [1:0] div_max;
	logic [sadc_pkg::CH_W-1:0] wr_ch;
	logic wr_on;

	assign sel = reg_sel(paddr);
	assign setup = psel && !penable;
	assign access = psel && penable && q_ff.pready;
	assign csr_wr = access && pwrite && pstrb[0] &&
		sel == sadc_pkg::SEL_CSR;
	assign drh_rd = access && !pwrite && sel == sadc_pkg::SEL_DRH;
	assign wr_ch = pwdata[sadc_pkg::CH_LSB +: sadc_pkg::CH_W];
	assign wr_on = pwdata[sadc_pkg::ON_BIT];

	// a new input while running aborts the conversion, see R5
	assign restart = csr_wr && q_ff.on && wr_on && wr_ch != q_ff.ch;

	// wait_mode is not used: wait leaves the converter running, see R16
	// halt and the settling window gate the converter, see R17
	assign sar_en = q_ff.on && !halt_mode &&
		q_ff.settle == '0; // see R1

	// converter clock tick, see R7
	assign div_max = q_ff.speed ? sadc_pkg::DIV_FAST :
		sadc_pkg::DIV_SLOW;
	assign tick = sar_en && !restart && q_ff.div == div_max;

	always_comb begin
		nxt_q = q_ff;

		// comparator crosses in from the analog side
		nxt_q.cmp_meta = cmp_hi_async;
		nxt_q.cmp_sync = q_ff.cmp_meta;

		// apb answer is prepared in the setup phase
		nxt_q.pready = setup;
		nxt_q.pslverr = 1'b0;
		nxt_q.prdata = '0;
		if (setup) begin
			unique case (sel)
				sadc_pkg::SEL_CSR: begin
					// reserved bit 4 always reads zero, see R15
					nxt_q.prdata[sadc_pkg::EOC_BIT] = q_ff.eoc;
					nxt_q.prdata[sadc_pkg::SPEED_BIT] = q_ff.speed;
					nxt_q.prdata[sadc_pkg::ON_BIT] = q_ff.on;
					nxt_q.prdata[sadc_pkg::CH_LSB +: sadc_pkg::CH_W] =
						q_ff.ch;
				end
				sadc_pkg::SEL_DRH: begin
					nxt_q.prdata[7:0] =
						q_ff.res[sadc_pkg::RES_W-1:sadc_pkg::HI_LSB]; // see R8
				end
				sadc_pkg::SEL_DRL: begin
					nxt_q.prdata[sadc_pkg::LO_W-1:0] =
						q_ff.res[sadc_pkg::LO_W-1:0]; // see R9
				end
				sadc_pkg::SEL_NONE: nxt_q.pslverr = 1'b1;
			endcase
		end

		// register writes take effect at the access edge
		if (csr_wr) begin
			nxt_q.speed = pwdata[sadc_pkg::SPEED_BIT];
			nxt_q.on = wr_on; // see R2
			nxt_q.ch = wr_ch; // see R6
			nxt_q.eoc = 1'b0; // see R4
		end
		if (drh_rd) begin
			nxt_q.eoc = 1'b0; // see R4
		end

		// completion is last so a same-cycle clear loses, see R3
		// only the polled flag reports completion, see R19
		if (sar_done) begin
			nxt_q.eoc = 1'b1;
			nxt_q.res = sar_code;
		end

		// divider restarts with every conversion start
		if (!sar_en || restart || tick) begin
			nxt_q.div = '0;
		end else begin
			nxt_q.div = q_ff.div + 1'b1;
		end

		// settling window after leaving halt, see R17
		if (halt_mode) begin
			nxt_q.settle = SETTLE_LOAD;
		end else if (q_ff.settle != '0) begin
			nxt_q.settle = q_ff.settle - 1'b1;
		end

		nxt_q.power = nxt_q.on && !halt_mode;
	end

	// everything, results included, clears to zero, see R18
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_ff <= '0;
		end else if (ce) begin
			q_ff <= nxt_q;
		end
	end

	sadc_sar #(
		.RES_W(sadc_pkg::RES_W),
		.SAMPLE_TICKS(sadc_pkg::SAMPLE_TICKS),
		.CNT_W(sadc_pkg::CNT_W)
	) u_sar (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.enable(sar_en),
		.restart(restart),
		.tick(tick),
		.cmp_hi(q_ff.cmp_sync),
		.done(sar_done),
		.code(sar_code),
		.sample(sar_sample)
	);

	assign prdata = q_ff.prdata;
	assign pready = q_ff.pready;
	assign pslverr = q_ff.pslverr;
	assign analog_power = q_ff.power;
	assign input_select = q_ff.ch; // see R6
	assign dac_code = sar_code;
	assign sample_hold = sar_sample;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence slow_run_s;
		tick && !q_ff.speed && ce
		##1 (ce && sar_en && !restart && !q_ff.speed)[*4];
	endsequence

	sequence fast_run_s;
		tick && q_ff.speed && ce
		##1 (ce && sar_en && !restart && q_ff.speed)[*2];
	endsequence

	eoc_on_done_a: assert property ( // see R3
		ce && sar_done |=> q_ff.eoc && q_ff.res == $past(sar_code)
	) else $error("completion did not set flag and result");

	high_read_clears_a: assert property ( // see R4
		ce && drh_rd && !sar_done |=> !q_ff.eoc
	) else $error("high result read left flag set");

	csr_write_clears_a: assert property ( // see R4
		ce && csr_wr && !sar_done |=> !q_ff.eoc
	) else $error("control write left flag set");

	off_stops_a: assert property ( // see R2
		ce && csr_wr && !wr_on ##1 ce |=> dac_code == '0 && !sample_hold
	) else $error("converter still active after switch-off");

	slow_divide_a: assert property ( // see R7
		slow_run_s |-> tick
	) else $error("slow converter clock not every fourth cycle");

	fast_divide_a: assert property ( // see R7
		fast_run_s |-> tick
	) else $error("fast converter clock not every second cycle");

	halt_off_a: assert property ( // see R17
		ce && halt_mode |=> !analog_power && q_ff.settle == SETTLE_LOAD
	) else $error("halt did not power down and reload settling");

	settle_gate_a: assert property ( // see R17
		q_ff.settle != '0 |-> !sar_en && !tick
	) else $error("converter ran during settling window");

	high_read_data_a: assert property ( // see R8
		ce && setup && sel == sadc_pkg::SEL_DRH |=>
		prdata[31:8] == '0 && prdata[7:0] ==
		$past(q_ff.res[sadc_pkg::RES_W-1:sadc_pkg::HI_LSB]) && pready
	) else $error("high result read data wrong");

	low_read_data_a: assert property ( // see R9
		ce && setup && sel == sadc_pkg::SEL_DRL |=>
		prdata[31:2] == '0 &&
		prdata[1:0] == $past(q_ff.res[1:0])
	) else $error("low result read data wrong");

	channel_abort_a: assert property ( // see R5
		ce && restart && !sar_done |=> !q_ff.eoc && sample_hold
	) else $error("input change did not abort and resample");

	bad_addr_a: assert property (
		ce && setup && sel == sadc_pkg::SEL_NONE |=> pslverr && pready
	) else $error("unmapped address not refused");

	pready_pulse_a: assert property (
		ce && pready |=> !pready
	) else $error("ready stood longer than one cycle");

	err_with_ready_a: assert property (
		pslverr |-> pready
	) else $error("error answer without ready");

	csr_read_data_a: assert property ( // see R3
		ce && setup && sel == sadc_pkg::SEL_CSR |=>
		prdata[31:8] == '0 && !prdata[4] &&
		prdata[sadc_pkg::EOC_BIT] == $past(q_ff.eoc)
	) else $error("control read data wrong");

	on_starts_sample_a: assert property ( // see R1
		ce && csr_wr && wr_on && !q_ff.on && !halt_mode &&
		q_ff.settle == '0 ##1 ce && !halt_mode |=> sample_hold
	) else $error("switch-on did not start sampling");

	select_follows_a: assert property ( // see R6
		ce && csr_wr |=> input_select == $past(wr_ch)
	) else $error("input select not taken from write");

	off_no_power_a: assert property ( // see R2
		!q_ff.on |-> !analog_power
	) else $error("converter powered while off");

	freeze_a: assert property (
		!ce |=> q_ff == $past(q_ff)
	) else $error("state moved while clock enable low");

	eoc_only_done_a: assert property ( // see R3
		ce && !q_ff.eoc && !sar_done |=> !q_ff.eoc
	) else $error("flag set without completion");

	result_hold_a: assert property ( // see R3
		ce && !sar_done |=> q_ff.res == $past(q_ff.res)
	) else $error("result changed without completion");

	restart_divider_a: assert property ( // see R5
		ce && restart |=> q_ff.div == '0
	) else $error("divider not restarted on input change");

	sync_chain_a: assert property (
		ce |=> q_ff.cmp_sync == $past(q_ff.cmp_meta)
	) else $error("comparator synchroniser broken");

	settle_loaded_a: assert property ( // see R17
		ce && $past(ce) && $fell(halt_mode) |->
		q_ff.settle == SETTLE_LOAD
	) else $error("settling window not loaded on wakeup");
endmodule : sadc_ctrl

/* tb/sadc_ctrl_tb.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: comparator is modelled from a per-input level table
// Notes: SETTLE_CYC shortened to 4; period checks assume 22 ticks
module sadc_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] A_CSR = 12'(sadc_pkg::CSR_ADDR);
	localparam logic [11:0] A_HI = 12'(sadc_pkg::DRH_ADDR);
	localparam logic [11:0] A_LO = 12'(sadc_pkg::DRL_ADDR);
	typedef struct {int v; logic [9:0] res;} sadc_row_s;
	// level per input beside the code it must give; -1 is below range
	sadc_row_s rows [16] = '{'{1, 10'h001}, '{512, 10'h200},
		'{-1, 10'h000}, '{2000, 10'h3FF}, '{0, 10'h000},
		'{511, 10'h1FF}, '{341, 10'h155}, '{1023, 10'h3FF},
		'{682, 10'h2AA}, '{252, 10'h0FC}, '{771, 10'h303},
		'{455, 10'h1C7}, '{568, 10'h238}, '{2, 10'h002},
		'{3, 10'h003}, '{257, 10'h101}};
	logic pclk, presetn, ce, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, input_select;
	logic pready, pslverr, halt_mode, wait_mode, cmp_hi_async;
	logic analog_power, sample_hold;
	logic [9:0] dac_code;
	logic [7:0] c;
	int err_count = 0;
	int samples_checked = 0;
	int p0, p1;
	// comparator: input at or above the trial level keeps the bit
	assign cmp_hi_async = rows[input_select].v >= int'(dac_code);
	sadc_ctrl #(.SETTLE_CYC(4)) uut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.halt_mode(halt_mode), .wait_mode(wait_mode),
		.cmp_hi_async(cmp_hi_async), .analog_power(analog_power),
		.input_select(input_select), .dac_code(dac_code),
		.sample_hold(sample_hold));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one idle edge after each transfer keeps psel from double writes
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer is sampled mid-cycle, where it has settled
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		rd = prdata;
		er = pslverr;
		// request stands until the access edge itself
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic poll();
		int n;
		n = 0;
		do begin
			apb(1'b0, A_CSR, 32'h0);
			n++;
		end while (rd[7] !== 1'b1 && n < 200);
		chk("eoc", 32'h1, 32'(rd[7]));
	endtask : poll
	task automatic per(output int p);
		logic h;
		int n;
		n = 0;
		p = 0;
		h = 1'b1;
		while (n < 2 && p < 900) begin
			@(negedge pclk);
			if (n == 1) p++;
			if (sample_hold === 1'b1 && h === 1'b0) n++;
			h = sample_hold;
		end
	endtask : per
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		halt_mode = 1'b0;
		wait_mode = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("power", 32'h0, 32'(analog_power));
		apb(1'b0, A_CSR, 32'h0);
		chk("csr", 32'h0, rd);
		apb(1'b0, A_HI, 32'h0);
		chk("hi", 32'h0, rd);
		apb(1'b0, A_LO, 32'h0);
		chk("lo", 32'h0, rd);
		// refused writes: masked strobe, read-only result; then an unmapped read
		pstrb <= 4'h0;
		apb(1'b1, A_CSR, 32'h7F);
		pstrb <= 4'hF;
		apb(1'b1, A_HI, 32'hFF);
		apb(1'b0, A_CSR, 32'h0);
		chk("csr", 32'h0, rd);
		apb(1'b0, 12'h1CC, 32'h0);
		chk("slverr", 32'h1, 32'(er));
		chk("prdata", 32'h0, rd);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			c = {1'b0, i[0], 1'b1, 1'b0, i[3:0]};
			wait_mode <= i[3];
			apb(1'b1, A_CSR, 32'(c));
			poll();
			if (i[1]) begin
				apb(1'b0, A_LO, 32'h0);
				chk("lo", 32'(rows[i].res[1:0]), rd);
			end
			apb(1'b0, A_HI, 32'h0);
			chk("hi", 32'(rows[i].res[9:2]), rd);
			apb(1'b0, A_CSR, 32'h0);
			chk("csr", 32'(c), rd);
			$display("test input %0d done", i);
		end
		wait_mode <= 1'b0;
		apb(1'b1, A_CSR, 32'h25);
		per(p0);
		chk("slow period", 32'd88, 32'(p0));
		apb(1'b1, A_CSR, 32'h65);
		per(p1);
		chk("fast period", 32'd44, 32'(p1));
		$display("test divider done");
		poll();
		apb(1'b1, A_CSR, 32'h65);
		apb(1'b0, A_CSR, 32'h0);
		chk("csr", 32'h65, rd);
		// halt stops conversions without losing the control bits
		halt_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("power", 32'h0, 32'(analog_power));
		repeat (200) @(posedge pclk);
		apb(1'b0, A_CSR, 32'h0);
		chk("csr", 32'h65, rd);
		halt_mode <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("power", 32'h1, 32'(analog_power));
		poll();
		apb(1'b0, A_HI, 32'h0);
		chk("hi", 32'h7F, rd);
		$display("test halt done");
		repeat (20) @(posedge pclk);
		apb(1'b1, A_CSR, 32'h45);
		chk("power", 32'h0, 32'(analog_power));
		repeat (200) @(posedge pclk);
		apb(1'b0, A_CSR, 32'h0);
		chk("csr", 32'h45, rd);
		chk("dac", 32'h0, 32'(dac_code));
		$display("test stop done");
		tally_and_finish();
	end
endmodule : sadc_ctrl_tb
